/* logic/gzc_core.sv */
// Function
// - In polling mode a reading leaves only after a host request.
// - Polling mode keeps measuring; requests return the latest value.
// - Streaming or polling mode is restored from persistent storage.
// - The raw unsmoothed value can be reported as well.
// - Filter strength is host set; larger means smoother and slower.
// - Samples arrive at a fixed two per second, whatever the filter.
// - Every zero operation except fine adjust overwrites the stored zero completely.
// - Known-gas zero uses host level times range multiplier.
// - Nitrogen zero takes no parameter and assumes zero CO2.
// - Fresh-air level programmable to full scale, default 400 ppm.
// - Fine adjust shifts zero by reported minus true value.
// - Auto-zero starts disabled, runs when enabled, can be forced.
// - Auto-zero acts like fresh-air zero using the period's level.
// - Auto-zero has its own reference level.
// - Auto-zero has initial delay and interval; timers restart on reset.
// - Compensation value replaces default, applies always, persists.
// - Sleep mode rejects reading and zero commands; never persists.
// - Streaming mode sends a reading twice per second unasked.
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`default_nettype none
module gzc_core
  import gzc_pkg::*;
#(
  parameter int unsigned SAMPLE_PERIOD = SAMPLE_CYCLES
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output      logic        hreadyout,
  output      logic        hresp,
  output      logic [31:0] hrdata,
  // Optical front end
  input  wire logic [15:0] sensor_raw,
  // Reading to serial formatter
  output      gzc_rd_t     reading,
  // Persistent storage
  input  wire gzc_nv_t     nv_rdata,
  output      gzc_nv_t     nv_wdata,
  output      logic        nv_store
);

  typedef struct packed {
    logic               loaded;
    gzc_mode_t          mode;
    logic               raw_sel;
    gzc_nv_t            nv;
    logic [24:0]        tick;
    logic [15:0]        az_cnt;
    logic               az_first;
    logic [15:0]        az_min;
    logic [15:0]        meas;
    logic [23:0]        filt;
    gzc_rd_t            rd;
    logic               reject;
    logic               nv_store;
    logic               wr_pend;
    logic [7:0]         waddr;
    logic               rdy;
    logic [31:0]        rdata;
  } gzc_state_t;

  gzc_state_t s_q, s_d;

  function automatic logic [15:0] sat16(input logic signed [17:0] x);
    if (x < 0) begin
      return 16'h0000;
    end else if (x > $signed({2'b00, FULL_SCALE})) begin
      return FULL_SCALE;
    end
    return x[15:0];
  endfunction : sat16

  function automatic logic signed [17:0] zero_of(input logic [15:0] m,
                                                 input logic [15:0] t);
    return $signed({2'b00, m}) - $signed({2'b00, t});
  endfunction : zero_of

  function automatic logic [3:0] shift_of(input logic [7:0] f);
    logic [3:0] sh;
    sh = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (f[i]) begin
        sh = 4'(i + 1);
      end
    end
    return sh;
  endfunction : shift_of

  logic        tick_now;
  logic        addr_ok;
  logic        poll_req;
  logic        zero_cmd;
  logic        az_fire;
  logic [31:0] prod;
  logic [15:0] meas_new;
  logic [15:0] min_new;
  logic signed [24:0] fdiff;
  logic [31:0] known;

  assign tick_now = s_q.tick == 25'(SAMPLE_PERIOD - 1);
  assign addr_ok  = hsel && htrans[1] && hready;
  assign poll_req = s_q.wr_pend && s_q.waddr == OFS_CTRL && hwdata[CTRL_REQ];
  assign zero_cmd = s_q.wr_pend && (s_q.waddr == OFS_KNOWN
                    || s_q.waddr == OFS_ADJUST
                    || (s_q.waddr == OFS_CTRL && (hwdata[CTRL_NITRO]
                        || hwdata[CTRL_FRESH] || hwdata[CTRL_FORCE])));
  assign prod     = sensor_raw * s_q.nv.comp;
  assign meas_new = |prod[31:29] ? FULL_SCALE
                    : prod[COMP_SHIFT +: 16];
  assign min_new  = meas_new < s_q.az_min ? meas_new : s_q.az_min;
  assign az_fire  = tick_now && s_q.mode != MODE_SLEEP && s_q.nv.az_en
                    && s_q.az_cnt + 16'h0001 >= (s_q.az_first
                    ? s_q.nv.az_init : s_q.nv.az_per);
  assign known    = hwdata[15:0] * s_q.nv.scale;

  always_comb begin
    s_d          = s_q;
    s_d.rd.valid = 1'b0;
    s_d.nv_store = 1'b0;
    s_d.rdy      = 1'b1;
    fdiff        = '0;
    if (!s_q.loaded) begin
      s_d.loaded = 1'b1;
      s_d.nv     = nv_rdata;
      s_d.mode   = nv_rdata.pmode == MODE_POLL ? MODE_POLL
                   : MODE_STREAM;
    end
    // Sampling
    s_d.tick = tick_now ? 25'h0 : s_q.tick + 25'h1;
    if (tick_now && s_q.mode != MODE_SLEEP) begin
      s_d.meas = meas_new;
      fdiff    = $signed({1'b0, meas_new, 8'h00})
                 - $signed({1'b0, s_q.filt});
      fdiff    = fdiff >>> shift_of(s_q.nv.filter);
      s_d.filt = s_q.filt + fdiff[23:0];
      if (s_q.nv.az_en) begin
        s_d.az_min = min_new;
        s_d.az_cnt = s_q.az_cnt + 16'h0001;
      end
      if (s_q.mode == MODE_STREAM) begin
        s_d.rd.valid = 1'b1;
        s_d.rd.raw   = s_q.raw_sel;
        s_d.rd.value = s_q.raw_sel
                       ? sat16(zero_of(meas_new, 16'h0000) - s_q.nv.zero)
                       : sat16(zero_of(s_d.filt[23:8], 16'h0000)
                               - s_q.nv.zero);
      end
    end
    if (az_fire) begin
      s_d.nv.zero  = zero_of(min_new, s_q.nv.az_ref);
      s_d.az_cnt   = 16'h0000;
      s_d.az_first = 1'b0;
      s_d.az_min   = MIN_INIT;
      s_d.nv_store = 1'b1;
    end
    // Bus address phase
    s_d.wr_pend = addr_ok && hwrite;
    if (addr_ok) begin
      s_d.waddr = {haddr[7:2], 2'b00};
    end
    s_d.rdata = 32'h0000_0000;
    if (addr_ok && !hwrite) begin
      case ({haddr[7:2], 2'b00})
        OFS_CTRL:   s_d.rdata = {26'h0, s_q.raw_sel, s_q.nv.az_en,
                                 2'b00, s_q.mode};
        OFS_FILTER: s_d.rdata = {24'h0, s_q.nv.filter};
        OFS_SCALE:  s_d.rdata = {16'h0, s_q.nv.scale};
        OFS_FRESH:  s_d.rdata = {16'h0, s_q.nv.fresh_ref};
        OFS_AZREF:  s_d.rdata = {16'h0, s_q.nv.az_ref};
        OFS_AZINIT: s_d.rdata = {16'h0, s_q.nv.az_init};
        OFS_AZPER:  s_d.rdata = {16'h0, s_q.nv.az_per};
        OFS_COMP:   s_d.rdata = {16'h0, s_q.nv.comp};
        OFS_ZERO:   s_d.rdata = {{14{s_q.nv.zero[17]}}, s_q.nv.zero};
        OFS_FILT:   s_d.rdata = {16'h0,
                                 sat16(zero_of(s_q.filt[23:8], 16'h0000)
                                       - s_q.nv.zero)};
        OFS_RAW:    s_d.rdata = {16'h0,
                                 sat16(zero_of(s_q.meas, 16'h0000)
                                       - s_q.nv.zero)};
        OFS_STATUS: s_d.rdata = {23'h0, s_q.reject, s_q.az_cnt[7:0]};
        default:    s_d.rdata = 32'h0000_0000;
      endcase
    end
    // Bus data phase
    if (s_q.mode == MODE_SLEEP && (zero_cmd || poll_req)) begin
      s_d.reject = 1'b1;
    end else if (s_q.wr_pend) begin
      s_d.nv_store = az_fire || s_q.waddr != OFS_STATUS;
      case (s_q.waddr)
        OFS_CTRL: begin
          if (hwdata[1:0] <= 2'(MODE_POLL)) begin
            s_d.mode = gzc_mode_t'(hwdata[1:0]);
            if (hwdata[1:0] != 2'(MODE_SLEEP)) begin
              s_d.nv.pmode = gzc_mode_t'(hwdata[1:0]);
            end
          end
          s_d.nv.az_en = hwdata[CTRL_AZEN];
          s_d.raw_sel  = hwdata[CTRL_RAWSEL];
          if (poll_req && s_q.mode == MODE_POLL) begin
            s_d.rd.valid = 1'b1;
            s_d.rd.raw   = hwdata[CTRL_RAWSEL];
            s_d.rd.value = hwdata[CTRL_RAWSEL]
                           ? sat16(zero_of(s_q.meas, 16'h0000)
                                   - s_q.nv.zero)
                           : sat16(zero_of(s_q.filt[23:8], 16'h0000)
                                   - s_q.nv.zero);
          end
          if (hwdata[CTRL_NITRO]) begin
            s_d.nv.zero = zero_of(s_q.meas, 16'h0000);
          end else if (hwdata[CTRL_FRESH]) begin
            s_d.nv.zero = zero_of(s_q.meas, s_q.nv.fresh_ref);
          end else if (hwdata[CTRL_FORCE]) begin
            s_d.nv.zero = zero_of(s_q.meas, s_q.nv.az_ref);
          end
        end
        OFS_FILTER: s_d.nv.filter = hwdata[7:0];
        OFS_KNOWN:  s_d.nv.zero   = zero_of(s_q.meas,
                                            |known[31:16] ? FULL_SCALE
                                            : known[15:0]);
        OFS_SCALE:  s_d.nv.scale  = hwdata[15:0];
        OFS_FRESH:  s_d.nv.fresh_ref = hwdata[15:0] > FULL_SCALE
                                       ? FULL_SCALE : hwdata[15:0];
        OFS_AZREF:  s_d.nv.az_ref  = hwdata[15:0];
        OFS_ADJUST: s_d.nv.zero    = s_q.nv.zero
                                     - zero_of(hwdata[31:16],
                                               hwdata[15:0]);
        OFS_AZINIT: s_d.nv.az_init = hwdata[15:0];
        OFS_AZPER:  s_d.nv.az_per  = hwdata[15:0];
        OFS_COMP:   s_d.nv.comp    = hwdata[15:0];
        OFS_STATUS: s_d.reject     = s_q.reject & ~hwdata[STAT_REJ];
        default:    s_d.nv_store   = az_fire;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q              <= '0;
      s_q.mode         <= MODE_STREAM;
      s_q.nv.pmode     <= MODE_STREAM;
      s_q.nv.fresh_ref <= FRESH_DEF;
      s_q.nv.az_ref    <= FRESH_DEF;
      s_q.nv.az_init   <= AZ_INIT_DEF;
      s_q.nv.az_per    <= AZ_PER_DEF;
      s_q.nv.comp      <= COMP_DEF;
      s_q.nv.scale     <= SCALE_DEF;
      s_q.az_first     <= 1'b1;
      s_q.az_min       <= MIN_INIT;
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout = s_q.rdy;
  assign hresp     = 1'b0;
  assign hrdata    = s_q.rdata;
  assign reading   = s_q.rd;
  assign nv_wdata  = s_q.nv;
  assign nv_store  = s_q.nv_store;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_POLL_ONLY_ON_REQ: assert property (
    s_q.rd.valid && $past(s_q.mode) == MODE_POLL |-> $past(poll_req))
    else $error("Polling reading without request");
  AST_STREAM_TICK: assert property (
    tick_now && s_q.mode == MODE_STREAM && s_q.loaded |=> s_q.rd.valid)
    else $error("Streaming reading missing");
  AST_POLL_MEASURES: assert property (
    tick_now && s_q.mode == MODE_POLL |=> s_q.meas == $past(meas_new))
    else $error("Polling mode stopped measuring");
  AST_FIXED_RATE: assert property (
    s_q.rd.valid && !$past(poll_req) |-> s_q.tick == 25'h0)
    else $error("Reading off the sample tick");
  AST_NITRO_ZERO: assert property (
    poll_req == 1'b0 && s_q.wr_pend && s_q.waddr == OFS_CTRL
    && hwdata[CTRL_NITRO] && s_q.mode != MODE_SLEEP && !az_fire
    |=> s_q.nv.zero == $signed({2'b00, $past(s_q.meas)}))
    else $error("Nitrogen zero wrong");
  AST_SLEEP_REJECT: assert property (
    s_q.mode == MODE_SLEEP && zero_cmd
    |=> s_q.reject && $stable(s_q.nv.zero))
    else $error("Sleep mode accepted zero command");
  AST_AZ_RESTART: assert property (
    az_fire |=> s_q.az_cnt == 16'h0000 && !s_q.az_first && s_q.nv_store)
    else $error("Auto-zero timer not restarted");
  AST_COMP_WRITE: assert property (
    s_q.wr_pend && s_q.waddr == OFS_COMP && s_q.mode != MODE_SLEEP
    |=> s_q.nv.comp == $past(hwdata[15:0]) && s_q.nv_store)
    else $error("Compensation not stored");
  AST_MODE_RESTORE: assert property (
    !s_q.loaded |=> s_q.mode != MODE_SLEEP
    && ($past(nv_rdata.pmode) != MODE_POLL || s_q.mode == MODE_POLL))
    else $error("Mode not restored");
  AST_POLL_REPLY: assert property (
    poll_req && s_q.mode == MODE_POLL |=> s_q.rd.valid)
    else $error("Polling request not answered");
  AST_SLEEP_QUIET: assert property (
    $past(s_q.mode) == MODE_SLEEP |-> !s_q.rd.valid)
    else $error("Reading sent in sleep mode");
  AST_KNOWN_ZERO: assert property (
    s_q.wr_pend && s_q.waddr == OFS_KNOWN && s_q.mode != MODE_SLEEP
    && !az_fire && known[31:16] == 16'h0000
    |=> s_q.nv.zero == $past(s_q.meas) - $past(known[15:0]))
    else $error("Known-gas zero wrong");
  AST_FRESH_ZERO: assert property (
    s_q.wr_pend && s_q.waddr == OFS_CTRL && s_q.mode != MODE_SLEEP
    && hwdata[CTRL_FRESH] && !hwdata[CTRL_NITRO] && !az_fire
    |=> s_q.nv.zero == $past(s_q.meas) - $past(s_q.nv.fresh_ref))
    else $error("Fresh-air zero wrong");
  AST_FORCE_ZERO: assert property (
    s_q.wr_pend && s_q.waddr == OFS_CTRL && s_q.mode != MODE_SLEEP
    && hwdata[CTRL_FORCE] && !hwdata[CTRL_NITRO] && !hwdata[CTRL_FRESH]
    && !az_fire
    |=> s_q.nv.zero == $past(s_q.meas) - $past(s_q.nv.az_ref))
    else $error("Forced auto-zero wrong");
  AST_ADJUST_ZERO: assert property (
    s_q.wr_pend && s_q.waddr == OFS_ADJUST && s_q.mode != MODE_SLEEP
    && !az_fire |=> s_q.nv.zero == $past(s_q.nv.zero)
    - ($past(hwdata[31:16]) - $past(hwdata[15:0])))
    else $error("Zero adjustment wrong");
  AST_AUTO_ZERO: assert property (
    az_fire && !s_q.wr_pend
    |=> s_q.nv.zero == $past(min_new) - $past(s_q.nv.az_ref))
    else $error("Auto-zero level wrong");
  AST_AZ_COUNT: assert property (
    tick_now && s_q.mode != MODE_SLEEP && s_q.nv.az_en && !az_fire
    |=> s_q.az_cnt == $past(s_q.az_cnt) + 16'h0001)
    else $error("Auto-zero timer not counting");
  AST_ZERO_STORED: assert property (
    s_q.loaded && $past(s_q.loaded) && $changed(s_q.nv.zero)
    |-> s_q.nv_store)
    else $error("Zero change not stored");
  AST_SAMPLE_HOLD: assert property (
    !tick_now |=> $stable(s_q.meas) && $stable(s_q.filt))
    else $error("Sample taken off the tick");

endmodule : gzc_core
`default_nettype wire

/* logic/gzc_pkg.sv */
`default_nettype none
package gzc_pkg;
  // Clock and sample timing
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned SAMPLE_MS     = 500;
  localparam int unsigned SAMPLE_CYCLES = CLK_HZ / 1000 * SAMPLE_MS;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_FILTER   = 8'h04;
  localparam logic [7:0] OFS_KNOWN    = 8'h08;
  localparam logic [7:0] OFS_SCALE    = 8'h0C;
  localparam logic [7:0] OFS_FRESH    = 8'h10;
  localparam logic [7:0] OFS_AZREF    = 8'h14;
  localparam logic [7:0] OFS_ADJUST   = 8'h18;
  localparam logic [7:0] OFS_AZINIT   = 8'h1C;
  localparam logic [7:0] OFS_AZPER    = 8'h20;
  localparam logic [7:0] OFS_COMP     = 8'h24;
  localparam logic [7:0] OFS_ZERO     = 8'h28;
  localparam logic [7:0] OFS_FILT     = 8'h2C;
  localparam logic [7:0] OFS_RAW      = 8'h30;
  localparam logic [7:0] OFS_STATUS   = 8'h34;

  // Control and status register fields
  localparam int unsigned CTRL_AZEN   = 4;
  localparam int unsigned CTRL_RAWSEL = 5;
  localparam int unsigned CTRL_REQ    = 8;
  localparam int unsigned CTRL_NITRO  = 9;
  localparam int unsigned CTRL_FRESH  = 10;
  localparam int unsigned CTRL_FORCE  = 11;
  localparam int unsigned STAT_REJ    = 8;

  // Reset and default values
  localparam logic [15:0] FRESH_DEF   = 16'h0190;
  localparam logic [15:0] COMP_DEF    = 16'h2000;
  localparam logic [15:0] SCALE_DEF   = 16'h0001;
  localparam logic [15:0] FULL_SCALE  = 16'hFFFF;
  localparam logic [15:0] AZ_INIT_DEF = 16'h00F0;
  localparam logic [15:0] AZ_PER_DEF  = 16'hFFFF;
  localparam logic [15:0] MIN_INIT    = 16'hFFFF;
  localparam int unsigned COMP_SHIFT  = 13;

  typedef enum logic [1:0] {
    MODE_SLEEP,
    MODE_STREAM,
    MODE_POLL
  } gzc_mode_t;

  // Settings kept across power loss
  typedef struct packed {
    gzc_mode_t          pmode;
    logic [7:0]         filter;
    logic [15:0]        fresh_ref;
    logic [15:0]        az_ref;
    logic               az_en;
    logic [15:0]        az_init;
    logic [15:0]        az_per;
    logic signed [17:0] zero;
    logic [15:0]        comp;
    logic [15:0]        scale;
  } gzc_nv_t;

  // Reading handed to the serial formatter
  typedef struct packed {
    logic        valid;
    logic        raw;
    logic [15:0] value;
  } gzc_rd_t;
endpackage : gzc_pkg
`default_nettype wire

/* tb/gzc_nv_model.sv */
`default_nettype none
module gzc_nv_model
  import gzc_pkg::*;
(
  // Clock
  input  wire logic    hclk,
  // Storage port
  input  wire gzc_nv_t nv_wdata,
  input  wire logic    nv_store,
  output var  gzc_nv_t nv_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Factory defaults; content survives every reset
  initial nv_rdata = '{MODE_STREAM, 8'h00, FRESH_DEF, FRESH_DEF, 1'b0,
    AZ_INIT_DEF, AZ_PER_DEF, 18'sh0, COMP_DEF, SCALE_DEF};
  always @(posedge hclk) begin
    if (nv_store === 1'b1) begin
      nv_rdata <= nv_wdata;
    end
  end
endmodule : gzc_nv_model
`default_nettype wire

/* tb/gas_sensor_mode_and_zero_control_test.sv */
`default_nettype none
module gas_sensor_mode_and_zero_control_test
  import gzc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned P = 20;
  logic        hclk, hresetn, hwrite, hreadyout, hresp, nv_store;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd, z0;
  logic [15:0] sensor_raw;
  gzc_rd_t     reading;
  gzc_nv_t     nv_rdata, nv_wdata;
  int          errors, compares, pulses;

  gzc_core #(.SAMPLE_PERIOD(P)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sensor_raw(sensor_raw), .reading(reading),
    .nv_rdata(nv_rdata), .nv_wdata(nv_wdata), .nv_store(nv_store));
  gzc_nv_model nv (.hclk(hclk), .nv_wdata(nv_wdata),
    .nv_store(nv_store), .nv_rdata(nv_rdata));

  always #10 hclk = ~hclk;
  always @(posedge hclk) begin
    if (reading.valid === 1'b1) begin
      pulses++;
    end
  end

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string n, input logic [31:0] e, s);
    compares++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    @(posedge hclk);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, rd);
  endtask : wr

  task automatic rchk(input string n, input logic [7:0] a,
                      input logic [31:0] e);
    xfer(1'b0, a, 32'h0, rd);
    chk(n, e, rd);
    chk("resp", 32'h0, {31'h0, hresp});
  endtask : rchk

  task automatic zchk(input string n, input logic [7:0] a,
                      input logic [31:0] d, e);
    wr(a, d);
    repeat (3 * P) @(posedge hclk);
    rchk(n, OFS_FILT, e);
  endtask : zchk

  task automatic preq(input string n, input logic [31:0] c,
                      input logic r, input logic [15:0] v);
    wr(OFS_CTRL, c);
    @(negedge hclk);
    chk(n, {14'h0, 1'b1, r, v},
        {14'h0, reading.valid, reading.raw, reading.value});
    @(posedge hclk);
  endtask : preq

  task automatic cnt(input string n, input int c, input logic [31:0] e);
    @(negedge hclk);
    pulses = 0;
    repeat (c) @(negedge hclk);
    chk(n, e, pulses);
    @(posedge hclk);
  endtask : cnt

  task automatic pwr();
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask : pwr

  initial begin
    repeat (20000) @(posedge hclk);
    errors++;
    wrap_up();
  end

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    sensor_raw = 16'h03E8;
    errors = 0;
    compares = 0;
    pulses = 0;
    @(posedge hclk);
    pwr();
    rchk("fresh", OFS_FRESH, {16'h0, FRESH_DEF});
    rchk("comp", OFS_COMP, {16'h0, COMP_DEF});
    rchk("unmapped", 8'h3C, 32'h0);
    rchk("status", OFS_STATUS, 32'h0);
    cnt("stream", 5 * P, 32'h5);
    $display("Test defaults done");
    wr(OFS_SCALE, 32'h2);
    zchk("known", OFS_KNOWN, 32'h96, 32'h12C);
    zchk("nitro", OFS_CTRL, 32'h201, 32'h0);
    zchk("adjust", OFS_ADJUST, 32'h0064_0000, 32'h64);
    zchk("fresh0", OFS_CTRL, 32'h401, 32'h190);
    wr(OFS_FRESH, 32'h1F4);
    zchk("fresh1", OFS_CTRL, 32'h401, 32'h1F4);
    wr(OFS_AZREF, 32'hFA);
    zchk("force", OFS_CTRL, 32'h801, 32'hFA);
    wr(OFS_CTRL, 32'h201);
    zchk("comp2", OFS_COMP, 32'h4000, 32'h3E8);
    zchk("comp1", OFS_COMP, 32'h2000, 32'h0);
    $display("Test zero done");
    wr(OFS_CTRL, 32'h2);
    @(posedge hclk);
    cnt("poll quiet", 5 * P, 32'h0);
    sensor_raw <= 16'h044C;
    repeat (3 * P) @(posedge hclk);
    preq("poll", 32'h102, 1'b0, 16'h0064);
    preq("raw", 32'h122, 1'b1, 16'h0064);
    $display("Test poll done");
    xfer(1'b0, OFS_ZERO, 32'h0, z0);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_KNOWN, 32'h5);
    rchk("reject", OFS_STATUS, 32'h100);
    rchk("zero kept", OFS_ZERO, z0);
    cnt("sleep quiet", 5 * P, 32'h0);
    $display("Test sleep done");
    pwr();
    cnt("poll back", 5 * P, 32'h0);
    preq("zero back", 32'h102, 1'b0, 16'h0064);
    rchk("comp back", OFS_COMP, 32'h2000);
    rchk("fresh back", OFS_FRESH, 32'h1F4);
    rchk("azref back", OFS_AZREF, 32'hFA);
    $display("Test power done");
    wr(OFS_FILTER, 32'h20);
    wr(OFS_CTRL, 32'h1);
    sensor_raw <= 16'h0834;
    repeat (2 * P) @(posedge hclk);
    xfer(1'b0, OFS_FILT, 32'h0, rd);
    chk("lag", 32'h1, rd > 32'h64 && rd < 32'h44C);
    rchk("raw", OFS_RAW, 32'h44C);
    cnt("rate", 5 * P, 32'h5);
    $display("Test filter done");
    wr(OFS_FILTER, 32'h0);
    wr(OFS_AZREF, 32'h12C);
    wr(OFS_AZINIT, 32'h2);
    wr(OFS_AZPER, 32'h3);
    zchk("auto", OFS_CTRL, 32'h11, 32'h12C);
    xfer(1'b0, OFS_STATUS, 32'h0, rd);
    chk("auto ran", 32'h1, rd[7:0] != 8'h0);
    pwr();
    rchk("timer restart", OFS_STATUS, 32'h0);
    $display("Test auto done");
    wrap_up();
  end
endmodule : gas_sensor_mode_and_zero_control_test
`default_nettype wire
